/* File: hw/tx_dma_pkg.sv */
// Shared constants for the transmit DMA request and oversize frame count block
package tx_dma_pkg;
  // Register indices on the local register port
  localparam logic [1:0] REG_FETCH_SPACE = 2'h0;
  localparam logic [1:0] REG_POLL_INTERVAL = 2'h1;
  localparam logic [1:0] REG_STARVE = 2'h2;
  localparam logic [1:0] REG_OVERSIZE_COUNT = 2'h3;
  // Reset values of the registers
  localparam logic [7:0] FETCH_SPACE_RESET = 8'h08;
  localparam logic [7:0] POLL_INTERVAL_RESET = 8'h01;
  localparam logic [7:0] STARVE_RESET = 8'h04;
  localparam logic [15:0] OVERSIZE_COUNT_RESET = 16'h0000;
  // Threshold floors and the size of one threshold step
  localparam logic [7:0] FETCH_SPACE_MIN = 8'h08;
  localparam logic [7:0] STARVE_MIN = 8'h04;
  localparam logic [7:0] POLL_INTERVAL_MIN = 8'h01;
  localparam int unsigned STEP_SHIFT = 5;
  // Oversize frame limits in bytes, destination address through FCS
  localparam logic [15:0] MAX_PLAIN_FRAME = 16'h05ee;
  localparam logic [15:0] MAX_TAGGED_FRAME = 16'h05f2;
  // Counter wrap point and near full event value as printed
  localparam logic [15:0] COUNT_WRAP_VALUE = 16'h0fff;
  localparam logic [19:0] COUNT_EVENT_VALUE = 20'hc0000;
  // Poll step time and the clock rate it is counted in
  localparam int unsigned POLL_STEP_NS = 320;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned POLL_STEP_CYCLES = (POLL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bit of the counter suppress mask that freezes the oversize count
  localparam int unsigned SUPPRESS_OVERSIZE_BIT = 19;
  // Bus owner selection
  typedef enum logic [1:0] {
    OWNER_NONE,
    OWNER_TX,
    OWNER_RX
  } bus_owner_t;
endpackage

/* File: hw/desc_poll_timer.sv */
// Periodic descriptor re-fetch timer in 320 ns steps
`timescale 1ns/10ps
module desc_poll_timer #(
  parameter int unsigned STEP_CYCLES = tx_dma_pkg::POLL_STEP_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [7:0] interval_i,
  output logic poll_o
);
  import tx_dma_pkg::*;

  localparam int unsigned STEP_W = $clog2(STEP_CYCLES);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);

  logic [STEP_W-1:0] step_cnt_ff;
  logic [7:0] tick_cnt_ff;
  logic step_tick;
  logic [7:0] eff_interval;

  // A zero interval would stop polling, so it is floored
  assign eff_interval = (interval_i < POLL_INTERVAL_MIN) ? POLL_INTERVAL_MIN : interval_i; // [R5]
  assign step_tick = run_i && (step_cnt_ff == STEP_LAST);

  // Divider giving one enable pulse per 320 ns step
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      step_cnt_ff <= '0;
    else if (!run_i || step_tick)
      step_cnt_ff <= '0;
    else
      step_cnt_ff <= step_cnt_ff + 1'b1;
  end

  // Count steps; restart whenever transmit DMA goes idle
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt_ff <= '0;
      poll_o <= 1'b0;
    end
    else
    begin
      poll_o <= 1'b0;
      if (!run_i)
        tick_cnt_ff <= '0;
      else if (step_tick)
      begin
        if (tick_cnt_ff + 8'h01 >= eff_interval) // [R4]
        begin
          tick_cnt_ff <= '0;
          poll_o <= 1'b1;
        end
        else
          tick_cnt_ff <= tick_cnt_ff + 8'h01;
      end
    end
  end
endmodule

/* File: hw/tx_dma_request.sv */
// Transmit DMA request logic, descriptor poll and oversize frame counter
//
// Behaviour
// R1 - A normal request may start once FIFO free bytes exceed the fetch threshold times 32.
// R2 - A transmit request is forced while FIFO used bytes exceed the current fragment length.
// R3 - The fetch threshold tops out at 0xff and any value under 0x08 acts as 0x08.
// R4 - While transmit DMA runs, the descriptor is re-fetched every poll interval times 320 ns.
// R5 - A poll interval under 0x01 acts as 0x01 so polling never stops, longest 81.6 us.
// R6 - An urgent request may start once FIFO used bytes fall under starve threshold times 32.
// R7 - An urgent transmit request beats receive DMA unless receive DMA is urgent too.
// R8 - The starve threshold tops out at 0xff and any value under 0x04 acts as 0x04.
// R9 - Each good transmitted frame longer than 1518 bytes, or 1522 when tagged, is counted.
// R10 - The oversize frame counter wraps to zero after its printed limit 0xfff.
// R11 - The near full event fires when the counter reaches the printed value 0xc0000; the 16-bit count wrapping at 0xfff never reaches it.
// R12 - The counter moves only while counters are on and its suppress bit is clear.
// R13 - Suppress mask bit 19 set to 1 freezes the oversize frame counter.
// R14 - Both request kinds share one master request; urgent supersedes normal until granted.
`timescale 1ns/10ps
module tx_dma_request #(
  parameter int unsigned FIFO_BYTES_W = 14,
  parameter logic [15:0] WRAP_VALUE = tx_dma_pkg::COUNT_WRAP_VALUE,
  parameter logic [19:0] EVENT_VALUE = tx_dma_pkg::COUNT_EVENT_VALUE
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Local register port
  input wire logic [1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // Transmit FIFO levels and current descriptor
  input wire logic tx_dma_active_i,
  input wire logic [FIFO_BYTES_W-1:0] fifo_free_bytes_i,
  input wire logic [FIFO_BYTES_W-1:0] fifo_used_bytes_i,
  input wire logic [15:0] fragment_length_i,
  // Shared bus master request and grant
  input wire logic rx_req_i,
  input wire logic rx_urgent_i,
  input wire logic mst_gnt_i,
  output logic mst_req_o,
  output logic mst_urgent_o,
  output logic tx_gnt_o,
  output logic rx_gnt_o,
  // Descriptor re-fetch strobe
  output logic desc_poll_o,
  // Transmitted frame report and counter gating
  input wire logic frame_ok_i,
  input wire logic [15:0] frame_length_i,
  input wire logic frame_tagged_i,
  input wire logic counters_on_i,
  input wire logic [31:0] counter_suppress_mask_i,
  output logic stats_near_full_event_o
);
  import tx_dma_pkg::*;

  // Byte threshold width, one spare bit so the compare never wraps
  localparam int unsigned THR_W = 8 + STEP_SHIFT + 1;

  // Stored register values, read back raw, and the urgent latch with its next state
  logic [7:0] fetch_space_ff;
  logic [7:0] poll_interval_ff;
  logic [7:0] starve_ff;
  logic [15:0] count_ff;
  logic urgent_pend_ff;
  logic nxt_urgent_pend;

  // Floored thresholds and their byte equivalents
  logic [7:0] eff_fetch;
  logic [7:0] eff_starve;
  logic [THR_W-1:0] fetch_bytes;
  logic [THR_W-1:0] starve_bytes;

  // Request conditions and arbitration
  logic normal_want;
  logic forced_want;
  logic urgent_want;
  logic tx_want;
  bus_owner_t owner;

  // Oversize frame counting
  logic oversize;
  logic count_en;
  logic [15:0] nxt_count;

  // Floors applied on use so the register reads back what was written
  assign eff_fetch = (fetch_space_ff < FETCH_SPACE_MIN) ? FETCH_SPACE_MIN : fetch_space_ff; // [R3]
  assign eff_starve = (starve_ff < STARVE_MIN) ? STARVE_MIN : starve_ff; // [R8]
  assign fetch_bytes = THR_W'(eff_fetch) << STEP_SHIFT; // [R1]
  assign starve_bytes = THR_W'(eff_starve) << STEP_SHIFT; // [R6]

  // Request conditions, only meaningful while transmit DMA runs
  assign normal_want = tx_dma_active_i && (THR_W'(fifo_free_bytes_i) > fetch_bytes); // [R1]
  assign forced_want = tx_dma_active_i
                       && (32'(fifo_used_bytes_i) > 32'(fragment_length_i)); // [R2]
  assign urgent_want = tx_dma_active_i && (THR_W'(fifo_used_bytes_i) < starve_bytes); // [R6]
  // Pending urgent keeps the request up until it is granted
  assign tx_want = normal_want || forced_want || urgent_pend_ff;

  // Next urgent latch state; a new urgent condition wins over the clearing grant
  always_comb
  begin
    nxt_urgent_pend = urgent_pend_ff;
    if (urgent_want)
      nxt_urgent_pend = 1'b1; // [R14]
    else if (tx_gnt_o || !tx_dma_active_i)
      nxt_urgent_pend = 1'b0; // [R14]
  end

  // Urgent latch register
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      urgent_pend_ff <= 1'b0;
    else
      urgent_pend_ff <= nxt_urgent_pend;
  end

  // One shared master request path for both transmit kinds and receive
  assign mst_req_o = tx_want || rx_req_i || rx_urgent_i; // [R14]

  // Urgent flag for the arbiter, from either side
  assign mst_urgent_o = urgent_pend_ff || rx_urgent_i;

  // Owner of a grant; normal receive goes ahead of normal transmit
  always_comb
  begin
    owner = OWNER_NONE;
    if (rx_urgent_i)
      owner = OWNER_RX; // [R7]
    else if (urgent_pend_ff)
      owner = OWNER_TX; // [R7]
    else if (rx_req_i)
      owner = OWNER_RX;
    else if (tx_want)
      owner = OWNER_TX;
  end

  // Grant steering follows the owner in the same cycle
  assign tx_gnt_o = mst_gnt_i && (owner == OWNER_TX);
  assign rx_gnt_o = mst_gnt_i && (owner == OWNER_RX);

  // Descriptor re-fetch timer
  desc_poll_timer u_poll (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(tx_dma_active_i),
    .interval_i(poll_interval_ff),
    .poll_o(desc_poll_o)
  ); // [R4] [R5]

  // Fetch threshold register
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fetch_space_ff <= FETCH_SPACE_RESET;
    else if (reg_wr_i && reg_addr_i == REG_FETCH_SPACE)
      fetch_space_ff <= reg_wdata_i[7:0];
  end

  // Poll interval register
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      poll_interval_ff <= POLL_INTERVAL_RESET;
    else if (reg_wr_i && reg_addr_i == REG_POLL_INTERVAL)
      poll_interval_ff <= reg_wdata_i[7:0];
  end

  // Starve threshold register
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      starve_ff <= STARVE_RESET;
    else if (reg_wr_i && reg_addr_i == REG_STARVE)
      starve_ff <= reg_wdata_i[7:0];
  end

  // Oversize frame detection and counting gate
  assign oversize = frame_tagged_i ? (frame_length_i > MAX_TAGGED_FRAME)
                                   : (frame_length_i > MAX_PLAIN_FRAME); // [R9]
  assign count_en = frame_ok_i && oversize && counters_on_i
                    && !counter_suppress_mask_i[SUPPRESS_OVERSIZE_BIT]; // [R12] [R13]
  // Wraps at the printed limit, not at the full field width
  assign nxt_count = (count_ff >= WRAP_VALUE) ? 16'h0000 : count_ff + 16'h0001; // [R10]

  // Counter; a software write takes precedence over a same-cycle frame
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_ff <= OVERSIZE_COUNT_RESET;
    else if (reg_wr_i && reg_addr_i == REG_OVERSIZE_COUNT)
      count_ff <= reg_wdata_i;
    else if (count_en)
      count_ff <= nxt_count; // [R9]
  end

  // Near full event, registered on the same edge that the count lands on the event value
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      stats_near_full_event_o <= 1'b0;
    else
      stats_near_full_event_o <= count_en && (20'(nxt_count) == EVENT_VALUE); // [R11]
  end

  // Registered read data; unknown indices cannot occur with two address bits
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
    begin
      if (reg_addr_i == REG_FETCH_SPACE)
        reg_rdata_o <= {8'h00, fetch_space_ff};
      else if (reg_addr_i == REG_POLL_INTERVAL)
        reg_rdata_o <= {8'h00, poll_interval_ff};
      else if (reg_addr_i == REG_STARVE)
        reg_rdata_o <= {8'h00, starve_ff};
      else
        reg_rdata_o <= count_ff;
    end
  end
endmodule

/* File: testbench/tx_dma_properties.sv */
// Port-level checker for the transmit DMA request block
`timescale 1ns/10ps
module tx_dma_properties #(
  parameter int unsigned FIFO_BYTES_W = 14
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic tx_dma_active_i,
  input wire logic [FIFO_BYTES_W-1:0] fifo_free_bytes_i,
  input wire logic [FIFO_BYTES_W-1:0] fifo_used_bytes_i,
  input wire logic [15:0] fragment_length_i,
  input wire logic rx_urgent_i,
  input wire logic mst_gnt_i,
  input wire logic mst_req_o,
  input wire logic mst_urgent_o,
  input wire logic tx_gnt_o,
  input wire logic rx_gnt_o,
  input wire logic desc_poll_o,
  input wire logic frame_ok_i,
  input wire logic counters_on_i,
  input wire logic [31:0] counter_suppress_mask_i,
  input wire logic stats_near_full_event_o
);
  logic [15:0] idle_ff;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Active cycles since the last poll; the longest interval is 255 steps of 64
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      idle_ff <= 16'h0000;
    else if (!tx_dma_active_i || desc_poll_o)
      idle_ff <= 16'h0000;
    else
      idle_ff <= idle_ff + 16'h0001;
  // Free space above the largest threshold must always request
  a_normal_space: assert property (tx_dma_active_i && fifo_free_bytes_i > 8160
    |-> mst_req_o)
    else $error("no request above top fetch threshold");
  a_forced_fragment: assert property (tx_dma_active_i
    && fifo_used_bytes_i > fragment_length_i |-> mst_req_o)
    else $error("no forced request past fragment length");
  a_poll_bounded: assert property (idle_ff <= 16'h4002)
    else $error("descriptor poll stopped");
  a_poll_spacing: assert property (desc_poll_o |=> !desc_poll_o [*8])
    else $error("descriptor polls too close");
  a_starve_urgent: assert property (tx_dma_active_i && fifo_used_bytes_i < 128
    |=> mst_urgent_o)
    else $error("no urgent request below floor");
  a_rx_urgent_wins: assert property (mst_gnt_i && rx_urgent_i |-> rx_gnt_o && !tx_gnt_o)
    else $error("urgent receive lost grant");
  a_tx_urgent_wins: assert property (mst_gnt_i && mst_urgent_o && !rx_urgent_i
    |-> tx_gnt_o && !rx_gnt_o)
    else $error("urgent transmit lost grant");
  a_urgent_held: assert property (tx_dma_active_i && mst_urgent_o && !rx_urgent_i
    && !tx_gnt_o |=> mst_urgent_o)
    else $error("urgent dropped before grant");
  a_urgent_requests: assert property (mst_urgent_o |-> mst_req_o)
    else $error("urgent without request");
  a_no_grant_idle: assert property (!mst_gnt_i |-> !tx_gnt_o && !rx_gnt_o)
    else $error("grant steered without bus grant");
  a_event_cause: assert property (stats_near_full_event_o
    |-> $past(frame_ok_i) && $past(counters_on_i)
    && !$past(counter_suppress_mask_i[19]))
    else $error("event without counted frame");
  c_tx_urgent: cover property (mst_urgent_o && tx_gnt_o);
  c_poll: cover property (desc_poll_o);
  c_event: cover property (stats_near_full_event_o);
endmodule

bind tx_dma_request tx_dma_properties #(.FIFO_BYTES_W(FIFO_BYTES_W)) i_props (
  .ref_clk_i, .rst_n_i, .tx_dma_active_i, .fifo_free_bytes_i, .fifo_used_bytes_i,
  .fragment_length_i, .rx_urgent_i, .mst_gnt_i, .mst_req_o, .mst_urgent_o, .tx_gnt_o,
  .rx_gnt_o, .desc_poll_o, .frame_ok_i, .counters_on_i, .counter_suppress_mask_i,
  .stats_near_full_event_o);

/* File: testbench/pci_arbiter_model.sv */
// Bus arbiter stand-in that grants the shared request
`timescale 1ns/10ps
module pci_arbiter_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [3:0] wait_i,
  output logic gnt_o
);
  logic [3:0] cnt_ff;
  // Grant after wait_i plus one request cycles, so slow hosts keep urgent requests pending
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      cnt_ff <= 4'h0;
      gnt_o <= 1'b0;
    end
    else if (!req_i)
    begin
      cnt_ff <= 4'h0;
      gnt_o <= 1'b0;
    end
    else if (cnt_ff >= wait_i)
      gnt_o <= 1'b1;
    else
      cnt_ff <= cnt_ff + 4'h1;
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the transmit DMA request block
`timescale 1ns/10ps
module testbench;
  import tx_dma_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, wr = 0, rd = 0, act = 0, rxr = 0, rxu = 0;
  logic fok = 0, tag = 0, con = 1, evs = 0, gnt, req, urg, tg, rg, pol, ev;
  logic [1:0] a = 0;
  logic [15:0] wd = 0, rdat, flen = 0, frag = 16'hffff;
  logic [13:0] fr = 0, us = 14'h0100;
  logic [31:0] msk = 0;
  int n_fail = 0, check_count = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  tx_dma_request #(.EVENT_VALUE(20'h00010)) i_dut (
    .ref_clk_i, .rst_n_i, .reg_addr_i(a), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .tx_dma_active_i(act),
    .fifo_free_bytes_i(fr), .fifo_used_bytes_i(us), .fragment_length_i(frag),
    .rx_req_i(rxr), .rx_urgent_i(rxu), .mst_gnt_i(gnt), .mst_req_o(req),
    .mst_urgent_o(urg), .tx_gnt_o(tg), .rx_gnt_o(rg), .desc_poll_o(pol),
    .frame_ok_i(fok), .frame_length_i(flen), .frame_tagged_i(tag),
    .counters_on_i(con), .counter_suppress_mask_i(msk), .stats_near_full_event_o(ev));
  pci_arbiter_model i_arb (.ref_clk_i, .rst_n_i, .req_i(req), .wait_i(4'h3), .gnt_o(gnt));
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr_reg(input logic [1:0] ad, input logic [15:0] d);
    @(posedge ref_clk_i);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] ad, input logic [15:0] e);
    @(posedge ref_clk_i);
    a <= ad;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 chk("register", e, rdat);
  endtask
  // FIFO levels, fragment length and receive requests, settled 1 ns later
  task automatic drv(input logic [13:0] f, u, input logic [15:0] g, input logic [1:0] r);
    @(posedge ref_clk_i);
    act <= 1'b1;
    fr <= f;
    us <= u;
    frag <= g;
    {rxu, rxr} <= r;
    #1;
  endtask
  task automatic send(input logic [15:0] len, input logic t, on, input logic [31:0] m);
    @(posedge ref_clk_i);
    fok <= 1'b1;
    flen <= len;
    tag <= t;
    con <= on;
    msk <= m;
    @(posedge ref_clk_i);
    fok <= 1'b0;
  endtask
  // Cycles between two successive poll pulses
  task automatic gap(input logic [15:0] e);
    int n;
    repeat (400) if (pol !== 1'b1) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    for (n = 1; pol !== 1'b1 && n < 400; n++) @(negedge ref_clk_i);
    chk("poll gap", e, n[15:0]);
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd_reg(REG_FETCH_SPACE, 16'h0008);
    rd_reg(REG_POLL_INTERVAL, 16'h0001);
    rd_reg(REG_STARVE, 16'h0004);
    rd_reg(REG_OVERSIZE_COUNT, 16'h0000);
    wr_reg(REG_FETCH_SPACE, 16'h0010);
    rd_reg(REG_FETCH_SPACE, 16'h0010);
    drv(14'd512, 14'd256, 16'hffff, 2'h0);
    chk("request", 0, req);
    drv(14'd513, 14'd256, 16'hffff, 2'h0);
    chk("request", 1, req);
    wr_reg(REG_FETCH_SPACE, 16'h0002);
    drv(14'd256, 14'd256, 16'hffff, 2'h0);
    chk("request", 0, req);
    drv(14'd257, 14'd256, 16'hffff, 2'h0);
    chk("request", 1, req);
    drv(14'd8161, 14'd256, 16'hffff, 2'h0);
    chk("request", 1, req);
    drv(14'd0, 14'd200, 16'd199, 2'h0);
    chk("request", 1, req);
    drv(14'd0, 14'd200, 16'd200, 2'h0);
    chk("request", 0, req);
    wr_reg(REG_STARVE, 16'h0002);
    drv(14'd0, 14'd128, 16'hffff, 2'h0);
    @(posedge ref_clk_i);
    #1 chk("urgent", 0, urg);
    drv(14'd0, 14'd127, 16'hffff, 2'h1);
    @(posedge ref_clk_i);
    #1 chk("urgent", 1, urg);
    repeat (8) if (gnt !== 1'b1) @(negedge ref_clk_i);
    chk("tx grant", 1, tg);
    drv(14'd0, 14'd127, 16'hffff, 2'h3);
    chk("rx grant", 1, rg);
    drv(14'd0, 14'd256, 16'hffff, 2'h0);
    wr_reg(REG_POLL_INTERVAL, 16'h0000);
    gap(16'd64);
    wr_reg(REG_POLL_INTERVAL, 16'h0002);
    gap(16'd128);
    gap(16'd128);
    send(16'd1518, 1'b0, 1'b1, 32'h0);
    send(16'd1519, 1'b0, 1'b1, 32'h0);
    send(16'd1522, 1'b1, 1'b1, 32'h0);
    send(16'd1523, 1'b1, 1'b1, 32'h0);
    send(16'd1600, 1'b0, 1'b0, 32'h0);
    send(16'd1600, 1'b0, 1'b1, 32'h00080000);
    rd_reg(REG_OVERSIZE_COUNT, 16'h0002);
    wr_reg(REG_OVERSIZE_COUNT, 16'h0ffe);
    send(16'd1600, 1'b0, 1'b1, 32'h0);
    rd_reg(REG_OVERSIZE_COUNT, 16'h0fff);
    send(16'd1600, 1'b0, 1'b1, 32'h0);
    rd_reg(REG_OVERSIZE_COUNT, 16'h0000);
    wr_reg(REG_OVERSIZE_COUNT, 16'h000f);
    send(16'd1600, 1'b0, 1'b1, 32'h0);
    repeat (3) @(negedge ref_clk_i) evs = evs | ev;
    chk("event", 1, evs);
    final_report;
  end
  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    #200000;
    n_fail++;
    final_report;
  end
endmodule
